// file: hdl/cdf_consts.svh
// Offsets, field positions, reset values and widths for the divide and fault slice
// Assumes inclusion by bare name from the package and the modules
`ifndef CDF_CONSTS_SVH
`define CDF_CONSTS_SVH

`define CDF_ADDR_W 8
`define CDF_OFS_CFG 8'h00
`define CDF_OFS_STAT 8'h04
`define CDF_OFS_CLR 8'h08
`define CDF_OFS_EN 8'h0c
`define CDF_OFS_EVT 8'h10

`define CDF_BIT_THREAD 0
`define CDF_BIT_SWTRIG 1
`define CDF_BIT_MISALIGN 3
`define CDF_BIT_DIV0 4
`define CDF_BIT_BFIGN 8
`define CDF_BIT_STACK_ALIGN_SEL 9
`define CDF_CFG_MASK 32'h0000_031b
`define CDF_CFG_RESET 32'h0000_0000

`define CDF_IRQ_W 5
`define CDF_IRQ_DIV0 0
`define CDF_IRQ_MISALIGN 1
`define CDF_IRQ_LOCKUP 2
`define CDF_IRQ_BFIGN 3
`define CDF_IRQ_SWDENY 4

`define CDF_PSR_ALIGN_BIT 9
`define CDF_DIV_STEPS 6'h20

`endif

// file: hdl/cdf_pkg.sv
// Types shared by the divide and fault slice
// Assumes the constants header is on the include path
`include "cdf_consts.svh"

package cdf_pkg;

  typedef enum logic [1:0] {
    CDF_DV_IDLE = 2'b00,
    CDF_DV_RUN = 2'b01,
    CDF_DV_DONE = 2'b10
  } cdf_dv_state_t;

  typedef struct packed {
    logic is_signed;
    logic has_rd;
    logic [3:0] rd;
    logic [3:0] rn;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic [3:0] flags;
  } cdf_div_req_t;

  typedef struct packed {
    logic [3:0] wr_idx;
    logic [31:0] quotient;
    logic [3:0] flags;
  } cdf_div_rsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic multi;
  } cdf_mem_acc_t;

  typedef struct packed {
    logic [31:0] sp;
    logic psr_align;
  } cdf_stack_t;

endpackage : cdf_pkg

// file: hdl/cdf_divider.sv
// Iterative radix-2 divider, one quotient bit per clock
// Assumes start is given only while idle and a nonzero divisor
`timescale 1ns/1ps

module cdf_divider
  import cdf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic is_signed_i,
  input wire logic [31:0] dividend_i,
  input wire logic [31:0] divisor_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] quot_o
);

  function automatic logic [31:0] mag32(input logic [31:0] v, input logic sgn);
    mag32 = (sgn && v[31]) ? (~v + 32'h0000_0001) : v;
  endfunction : mag32

  cdf_dv_state_t st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [32:0] rem_r, rem_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [31:0] dvs_r, dvs_nxt;
  logic neg_r, neg_nxt;
  logic [32:0] trial;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    dvs_nxt = dvs_r;
    neg_nxt = neg_r;
    trial = {rem_r[31:0], quo_r[31]} - {1'b0, dvs_r};
    unique case (st_r)
      CDF_DV_IDLE:
      begin
        if (start_i)
        begin
          // Work on magnitudes so the result truncates toward zero
          quo_nxt = mag32(dividend_i, is_signed_i);
          dvs_nxt = mag32(divisor_i, is_signed_i);
          neg_nxt = is_signed_i && (dividend_i[31] ^ divisor_i[31]);
          rem_nxt = 33'h0_0000_0000;
          cnt_nxt = `CDF_DIV_STEPS;
          st_nxt = CDF_DV_RUN;
        end
      end
      CDF_DV_RUN:
      begin
        if (!trial[32])
        begin
          rem_nxt = trial;
          quo_nxt = {quo_r[30:0], 1'b1};
        end
        else
        begin
          rem_nxt = {rem_r[31:0], quo_r[31]};
          quo_nxt = {quo_r[30:0], 1'b0};
        end
        cnt_nxt = cnt_r - 6'h01;
        if (cnt_r == 6'h01)
          st_nxt = CDF_DV_DONE;
      end
      CDF_DV_DONE:
      begin
        // Remainder is simply dropped; only the quotient is kept
        quo_nxt = neg_r ? (~quo_r + 32'h0000_0001) : quo_r;
        st_nxt = CDF_DV_IDLE;
      end
      default:
        st_nxt = CDF_DV_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= CDF_DV_IDLE;
      cnt_r <= 6'h00;
      rem_r <= 33'h0_0000_0000;
      quo_r <= 32'h0000_0000;
      dvs_r <= 32'h0000_0000;
      neg_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      dvs_r <= dvs_nxt;
      neg_r <= neg_nxt;
    end
  end

  assign busy_o = (st_r != CDF_DV_IDLE);
  assign done_o = (st_r == CDF_DV_DONE);
  assign quot_o = quo_nxt;

endmodule : cdf_divider

// file: hdl/cdf_core.sv
// Divide unit, send-event hint and configuration-and-control register slice
// Assumes one core clock, synchronous reset and a classic Wishbone master
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps

`include "cdf_consts.svh"

module cdf_core
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`CDF_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Divide
  input wire logic div_req_valid_i,
  input wire cdf_pkg::cdf_div_req_t div_req_i,
  output logic div_req_ready_o,
  output logic div_rsp_valid_o,
  output cdf_pkg::cdf_div_rsp_t div_rsp_o,
  output logic div0_fault_o,
  // Send event
  input wire logic sev_i,
  input wire logic event_clear_i,
  output logic sev_out_o,
  output logic event_reg_o,
  // Exception entry and return
  input wire logic exc_entry_i,
  input wire logic exc_return_i,
  input wire cdf_pkg::cdf_stack_t stack_i,
  input wire logic ret_to_thread_i,
  input wire logic nested_active_i,
  output logic stack_valid_o,
  output cdf_pkg::cdf_stack_t stack_o,
  output logic thread_entry_fault_o,
  // Faults and access checks
  input wire logic dbus_fault_i,
  input wire logic hiprio_i,
  input wire logic acc_valid_i,
  input wire cdf_pkg::cdf_mem_acc_t acc_i,
  input wire logic swtrig_wr_i,
  input wire logic swtrig_priv_i,
  output logic busfault_o,
  output logic lockup_o,
  output logic usage_fault_o,
  output logic swtrig_ok_o,
  output logic irq_o
);

  import cdf_pkg::*;

  function automatic logic misaligned(input cdf_mem_acc_t a);
    unique case (a.size)
      2'b01: misaligned = a.addr[0];
      2'b10: misaligned = a.addr[1:0] != 2'b00;
      2'b11: misaligned = a.addr[1:0] != 2'b00;
      default: misaligned = 1'b0;
    endcase
  endfunction : misaligned

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] cfg_r, cfg_nxt;
  logic [`CDF_IRQ_W-1:0] stat_r, stat_nxt;
  logic [`CDF_IRQ_W-1:0] en_r, en_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic ack_r, ack_nxt;
  logic [`CDF_IRQ_W-1:0] evt_set;
  logic wr_go;
  logic event_r, event_nxt;
  logic lockup_r, lockup_nxt;
  logic lockup_o_q;

  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  always_comb
  begin
    cfg_nxt = cfg_r;
    en_nxt = en_r;
    stat_nxt = stat_r;
    rdat_nxt = rdat_r;
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    if (wr_go)
    begin
      unique case (wb_adr_i)
        `CDF_OFS_CFG:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b])
              cfg_nxt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
          end
          cfg_nxt = cfg_nxt & `CDF_CFG_MASK;
        end
        `CDF_OFS_EN:
          if (wb_sel_i[0])
            en_nxt = wb_dat_i[`CDF_IRQ_W-1:0];
        `CDF_OFS_CLR:
          if (wb_sel_i[0])
            stat_nxt = stat_r & ~wb_dat_i[`CDF_IRQ_W-1:0];
        default:
          ;
      endcase
    end
    // New events win over a clear in the same cycle
    stat_nxt = stat_nxt | evt_set;
    if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `CDF_OFS_CFG: rdat_nxt = cfg_r & `CDF_CFG_MASK;
        `CDF_OFS_STAT: rdat_nxt = {{(32-`CDF_IRQ_W){1'b0}}, stat_r};
        `CDF_OFS_EN: rdat_nxt = {{(32-`CDF_IRQ_W){1'b0}}, en_r};
        `CDF_OFS_EVT: rdat_nxt = {30'h0, lockup_r, event_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
    else if (!ack_r)
      rdat_nxt = 32'h0000_0000;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_r <= `CDF_CFG_RESET;
      stat_r <= '0;
      en_r <= '0;
      rdat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      rdat_r <= rdat_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq_o = |(stat_r & en_r);

  //////////////////////////////////////////////////////////////////////////////
  // Divide control
  cdf_dv_state_t dv_r, dv_nxt;
  cdf_div_rsp_t rsp_r, rsp_nxt;
  logic rsp_v_r, rsp_v_nxt;
  logic d0f_r, d0f_nxt;
  logic dv_start, dv_busy, dv_done;
  logic [31:0] dv_quot;
  logic div_take, div_zero;

  assign div_take = div_req_valid_i && (dv_r == CDF_DV_IDLE);
  assign div_zero = div_req_i.divisor == 32'h0000_0000;
  assign dv_start = div_take && !div_zero;

  always_comb
  begin
    dv_nxt = dv_r;
    rsp_nxt = rsp_r;
    rsp_v_nxt = 1'b0;
    d0f_nxt = 1'b0;
    unique case (dv_r)
      CDF_DV_IDLE:
      begin
        if (div_take)
        begin
          // Register index is used as given; stack pointer and pc are never named
          rsp_nxt.wr_idx = div_req_i.has_rd ? div_req_i.rd : div_req_i.rn;
          rsp_nxt.flags = div_req_i.flags;
          if (div_zero && cfg_r[`CDF_BIT_DIV0])
            d0f_nxt = 1'b1;
          else if (div_zero)
          begin
            rsp_nxt.quotient = 32'h0000_0000;
            rsp_v_nxt = 1'b1;
          end
          else
            dv_nxt = CDF_DV_RUN;
        end
      end
      CDF_DV_RUN:
      begin
        if (dv_done)
        begin
          rsp_nxt.quotient = dv_quot;
          rsp_v_nxt = 1'b1;
          dv_nxt = CDF_DV_IDLE;
        end
      end
      default:
        dv_nxt = CDF_DV_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dv_r <= CDF_DV_IDLE;
      rsp_r <= '0;
      rsp_v_r <= 1'b0;
      d0f_r <= 1'b0;
    end
    else
    begin
      dv_r <= dv_nxt;
      rsp_r <= rsp_nxt;
      rsp_v_r <= rsp_v_nxt;
      d0f_r <= d0f_nxt;
    end
  end

  cdf_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(dv_start),
    .is_signed_i(div_req_i.is_signed),
    .dividend_i(div_req_i.dividend),
    .divisor_i(div_req_i.divisor),
    .busy_o(dv_busy),
    .done_o(dv_done),
    .quot_o(dv_quot)
  );

  assign div_req_ready_o = (dv_r == CDF_DV_IDLE) && !dv_busy;
  assign div_rsp_valid_o = rsp_v_r;
  assign div_rsp_o = rsp_r;
  assign div0_fault_o = d0f_r;

  //////////////////////////////////////////////////////////////////////////////
  // Send event; no flag state lives here, so the flags cannot change
  logic sev_r, sev_nxt;

  always_comb
  begin
    sev_nxt = sev_i;
    event_nxt = event_r;
    if (event_clear_i)
      event_nxt = 1'b0;
    // A hint in the clearing cycle still leaves the register set
    if (sev_i)
      event_nxt = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      event_r <= 1'b0;
      sev_r <= 1'b0;
    end
    else
    begin
      event_r <= event_nxt;
      sev_r <= sev_nxt;
    end
  end

  assign sev_out_o = sev_r;
  assign event_reg_o = event_r;

  //////////////////////////////////////////////////////////////////////////////
  // Exception entry and return stack handling
  cdf_stack_t stk_r, stk_nxt;
  logic stk_v_r, stk_v_nxt;
  logic thr_f_r, thr_f_nxt;

  always_comb
  begin
    stk_nxt = stk_r;
    stk_v_nxt = 1'b0;
    thr_f_nxt = 1'b0;
    if (exc_entry_i)
    begin
      // Eight-byte mode pads one word when the frame would land misaligned
      if (cfg_r[`CDF_BIT_STACK_ALIGN_SEL] && stack_i.sp[2])
      begin
        stk_nxt.sp = {stack_i.sp[31:3], 3'b000};
        stk_nxt.psr_align = 1'b1;
      end
      else
      begin
        stk_nxt.sp = {stack_i.sp[31:2], 2'b00};
        stk_nxt.psr_align = 1'b0;
      end
      stk_v_nxt = 1'b1;
    end
    else if (exc_return_i)
    begin
      stk_nxt.sp = stack_i.psr_align ? (stack_i.sp + 32'h0000_0004) : stack_i.sp;
      stk_nxt.psr_align = stack_i.psr_align;
      stk_v_nxt = 1'b1;
      // Thread return with handlers still active is refused unless enabled
      thr_f_nxt = ret_to_thread_i && nested_active_i && !cfg_r[`CDF_BIT_THREAD];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stk_r <= '0;
      stk_v_r <= 1'b0;
      thr_f_r <= 1'b0;
    end
    else
    begin
      stk_r <= stk_nxt;
      stk_v_r <= stk_v_nxt;
      thr_f_r <= thr_f_nxt;
    end
  end

  assign stack_o = stk_r;
  assign stack_valid_o = stk_v_r;
  assign thread_entry_fault_o = thr_f_r;

  //////////////////////////////////////////////////////////////////////////////
  // Bus fault, access alignment and software trigger checks
  logic bf_r, bf_nxt;
  logic uf_r, uf_nxt;
  logic swok_r, swok_nxt;
  logic bf_ign, mis_fault, sw_deny;

  assign bf_ign = dbus_fault_i && hiprio_i && cfg_r[`CDF_BIT_BFIGN];
  // Multi-register transfers move words, so they check word alignment
  assign mis_fault = acc_valid_i &&
                     (acc_i.multi ? (acc_i.addr[1:0] != 2'b00) : misaligned(acc_i)) &&
                     (acc_i.multi || acc_i.size == 2'b11 || cfg_r[`CDF_BIT_MISALIGN]);
  assign sw_deny = swtrig_wr_i && !swtrig_priv_i && !cfg_r[`CDF_BIT_SWTRIG];

  always_comb
  begin
    // Lock-up holds until reset; software cannot recover a locked core
    lockup_nxt = lockup_r || (dbus_fault_i && hiprio_i && !cfg_r[`CDF_BIT_BFIGN]);
    bf_nxt = dbus_fault_i && !hiprio_i;
    uf_nxt = mis_fault;
    swok_nxt = swtrig_wr_i && !sw_deny;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lockup_r <= 1'b0;
      bf_r <= 1'b0;
      uf_r <= 1'b0;
      swok_r <= 1'b0;
    end
    else
    begin
      lockup_r <= lockup_nxt;
      bf_r <= bf_nxt;
      uf_r <= uf_nxt;
      swok_r <= swok_nxt;
    end
  end

  assign lockup_o = lockup_r;
  assign busfault_o = bf_r;
  assign usage_fault_o = uf_r;
  assign swtrig_ok_o = swok_r;

  always_comb
  begin
    evt_set = '0;
    evt_set[`CDF_IRQ_DIV0] = d0f_r;
    evt_set[`CDF_IRQ_MISALIGN] = uf_r;
    evt_set[`CDF_IRQ_LOCKUP] = lockup_r && !lockup_o_q;
    evt_set[`CDF_IRQ_BFIGN] = bf_ign;
    evt_set[`CDF_IRQ_SWDENY] = sw_deny;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lockup_o_q <= 1'b0;
    else
      lockup_o_q <= lockup_r;
  end

endmodule : cdf_core

// file: sim/cdf_core_monitor.sv
// Concurrent checks on the divide, event, stack and access ports of cdf_core
// Assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps

module cdf_core_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic div_req_valid_i,
  input wire cdf_pkg::cdf_div_req_t div_req_i,
  input wire logic div_req_ready_o,
  input wire logic div_rsp_valid_o,
  input wire cdf_pkg::cdf_div_rsp_t div_rsp_o,
  input wire logic sev_i,
  input wire logic sev_out_o,
  input wire logic event_reg_o,
  input wire logic exc_entry_i,
  input wire logic exc_return_i,
  input wire logic ret_to_thread_i,
  input wire cdf_pkg::cdf_stack_t stack_i,
  input wire logic stack_valid_o,
  input wire cdf_pkg::cdf_stack_t stack_o,
  input wire logic acc_valid_i,
  input wire cdf_pkg::cdf_mem_acc_t acc_i,
  input wire logic usage_fault_o,
  input wire logic lockup_o
);
  import cdf_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  logic [3:0] idx_r;
  logic [3:0] flg_r;
  logic [31:0] quo_r;
  assign take = div_req_valid_i && div_req_ready_o;
  ////////////////////////////////////////////////
  // Expectation is frozen at the take, operands may change meanwhile
  always_ff @(posedge clk_i)
  begin
    if (take)
    begin
      idx_r <= div_req_i.has_rd ? div_req_i.rd : div_req_i.rn;
      flg_r <= div_req_i.flags;
      if (div_req_i.divisor == 32'h0)
        quo_r <= 32'h0;
      else if (div_req_i.is_signed)
        quo_r <= $signed(div_req_i.dividend) / $signed(div_req_i.divisor);
      else
        quo_r <= div_req_i.dividend / div_req_i.divisor;
    end
  end
  sequence s_take_run;
    take && div_req_i.divisor != 32'h0;
  endsequence
  sequence s_busy_then_done;
    !div_req_ready_o ##33 div_rsp_valid_o;
  endsequence
  a_divide_latency:
    assert property (s_take_run |=> s_busy_then_done)
    else $error("Divide answer late or early");
  a_quotient_value:
    assert property (div_rsp_valid_o |-> div_rsp_o.quotient == quo_r)
    else $error("Wrong quotient");
  a_dest_index:
    assert property (div_rsp_valid_o |-> div_rsp_o.wr_idx == idx_r)
    else $error("Wrong destination");
  a_flags_kept:
    assert property (div_rsp_valid_o |-> div_rsp_o.flags == flg_r)
    else $error("Flags changed");
  a_event_raise:
    assert property (sev_i |=> sev_out_o && event_reg_o)
    else $error("Event not raised");
  a_entry_align:
    assert property (exc_entry_i |=> stack_valid_o && (stack_o.psr_align ?
      stack_o.sp == ($past(stack_i.sp) & 32'hffff_fff8) : stack_o.sp == $past(stack_i.sp)))
    else $error("Entry stack wrong");
  a_return_restore:
    assert property (exc_return_i && stack_i.psr_align && !ret_to_thread_i |=>
      stack_valid_o && stack_o.sp == $past(stack_i.sp) + 32'h4)
    else $error("Return stack wrong");
  a_multi_misalign:
    assert property (acc_valid_i && acc_i.multi && acc_i.addr[1:0] != 2'b00 |=> usage_fault_o)
    else $error("Multi access not faulted");
  a_lockup_holds:
    assert property (lockup_o |=> lockup_o)
    else $error("Lockup dropped");
endmodule : cdf_core_monitor

bind cdf_core cdf_core_monitor u_mon (.*);

// file: sim/cdf_core_tb.sv
// Bench for cdf_core: registers, divides, event hint, stacking, access checks
// Assumes the monitor binds itself to cdf_core
`timescale 1ns/1ps

`include "cdf_consts.svh"

module cdf_core_tb;
  import cdf_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [`CDF_ADDR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic div_req_valid_i, div_req_ready_o, div_rsp_valid_o, div0_fault_o;
  cdf_div_req_t div_req_i;
  cdf_div_rsp_t div_rsp_o;
  logic sev_i, event_clear_i, sev_out_o, event_reg_o, exc_entry_i, exc_return_i;
  cdf_stack_t stack_i, stack_o;
  logic ret_to_thread_i, nested_active_i, stack_valid_o, thread_entry_fault_o;
  logic dbus_fault_i, hiprio_i, acc_valid_i, swtrig_wr_i, swtrig_priv_i;
  cdf_mem_acc_t acc_i;
  logic busfault_o, lockup_o, usage_fault_o, swtrig_ok_o, irq_o;
  logic [5:0] ov;
  int n_fail = 0;
  int comparisons = 0;
  assign ov = {busfault_o, lockup_o, usage_fault_o, swtrig_ok_o, sev_out_o, event_reg_o};
  cdf_core uut (.*);
  ////////////////////////////////////////////////
  task automatic tk;
    @(posedge clk_i);
  endtask : tk
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  // Classic cycle; ack is sampled at the edge, so read data is taken there too
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    tk();
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do
    begin
      tk();
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    chk(n < 40, 1'b1);
  endtask : wb
  task automatic cfg(input logic [31:0] v);
    wb(1'b1, `CDF_OFS_CFG, v);
  endtask : cfg
  task automatic dv(input logic s, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] q, input logic f);
    int n;
    n = 0;
    tk();
    // Register indices stay clear of stack pointer and pc
    div_req_i <= '{s, s, 4'h2, 4'h5, a, b, 4'h9};
    div_req_valid_i <= 1'b1;
    // Request stands until ready is sampled high; one-cycle answers are read at the edge
    do
      tk();
    while (div_req_ready_o !== 1'b1);
    div_req_valid_i <= 1'b0;
    do
    begin
      tk();
      n++;
    end
    while ((div_rsp_valid_o | div0_fault_o) !== 1'b1 && n < 60);
    chk(n < 60, 1'b1);
    chk(div0_fault_o, f);
    if (!f)
      chk(div_rsp_o, {s ? 4'h2 : 4'h5, q, 4'h9});
  endtask : dv
  task automatic ex(input logic e, input logic [32:0] st, input logic t);
    tk();
    stack_i <= st;
    {ret_to_thread_i, nested_active_i} <= {t, t};
    {exc_entry_i, exc_return_i} <= {e, !e};
    tk();
    {exc_entry_i, exc_return_i} <= 2'b00;
    #1;
  endtask : ex
  // One pulse on any of bus fault, trigger write, access, event clear, event
  task automatic pz(input logic [4:0] p, input logic [34:0] ac, input logic [1:0] q);
    tk();
    acc_i <= ac;
    {hiprio_i, swtrig_priv_i} <= q;
    {dbus_fault_i, swtrig_wr_i, acc_valid_i, event_clear_i, sev_i} <= p;
    tk();
    {dbus_fault_i, swtrig_wr_i, acc_valid_i, event_clear_i, sev_i} <= 5'h0;
    #1;
  endtask : pz
  ////////////////////////////////////////////////
  task automatic t_regs;
    wb(1'b0, `CDF_OFS_CFG, 32'h0);
    chk(rd, 32'h0);
    cfg(32'hffff_ffff);
    wb(1'b0, `CDF_OFS_CFG, 32'h0);
    chk(rd, 32'h0000_031b);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs
  task automatic t_div;
    cfg(32'h0);
    dv(1'b1, 32'hffff_fff9, 32'h2, 32'hffff_fffd, 1'b0);
    dv(1'b1, 32'h7, 32'hffff_fffe, 32'hffff_fffd, 1'b0);
    dv(1'b0, 32'hffff_fff9, 32'h2, 32'h7fff_fffc, 1'b0);
    dv(1'b0, 32'h64, 32'h0, 32'h0, 1'b0);
    wb(1'b1, `CDF_OFS_EN, 32'h1f);
    cfg(32'h10);
    dv(1'b1, 32'h64, 32'h0, 32'h0, 1'b1);
    wb(1'b0, `CDF_OFS_STAT, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, `CDF_OFS_EN, 32'h0);
    #1;
    chk(irq_o, 1'b0);
    wb(1'b1, `CDF_OFS_EN, 32'h1);
    #1;
    chk(irq_o, 1'b1);
    wb(1'b1, `CDF_OFS_CLR, 32'h1);
    #1;
    chk(irq_o, 1'b0);
  endtask : t_div
  task automatic t_sev;
    pz(5'h01, 35'h0, 2'b00);
    chk(ov, 6'h03);
    pz(5'h02, 35'h0, 2'b00);
    chk(ov, 6'h00);
  endtask : t_sev
  task automatic t_stack;
    cfg(32'h0);
    ex(1'b1, {32'h2004, 1'b0}, 1'b0);
    chk({stack_valid_o, stack_o}, {1'b1, 32'h2004, 1'b0});
    cfg(32'h200);
    ex(1'b1, {32'h2004, 1'b0}, 1'b0);
    chk({stack_valid_o, stack_o}, {1'b1, 32'h2000, 1'b1});
    ex(1'b0, {32'h2000, 1'b1}, 1'b0);
    chk({stack_valid_o, stack_o.sp}, {1'b1, 32'h2004});
    cfg(32'h0);
    ex(1'b0, {32'h2000, 1'b0}, 1'b1);
    chk(thread_entry_fault_o, 1'b1);
    cfg(32'h1);
    ex(1'b0, {32'h2000, 1'b0}, 1'b1);
    chk(thread_entry_fault_o, 1'b0);
  endtask : t_stack
  task automatic t_acc;
    cfg(32'h0);
    pz(5'h04, {32'h101, 2'b10, 1'b0}, 2'b00);
    chk(ov, 6'h00);
    pz(5'h04, {32'h102, 2'b00, 1'b1}, 2'b00);
    chk(ov, 6'h08);
    pz(5'h04, {32'h106, 2'b11, 1'b0}, 2'b00);
    chk(ov, 6'h08);
    cfg(32'h8);
    pz(5'h04, {32'h103, 2'b01, 1'b0}, 2'b00);
    chk(ov, 6'h08);
    pz(5'h04, {32'h102, 2'b01, 1'b0}, 2'b00);
    chk(ov, 6'h00);
  endtask : t_acc
  task automatic t_swtrig;
    cfg(32'h0);
    pz(5'h08, 35'h0, 2'b00);
    chk(ov, 6'h00);
    pz(5'h08, 35'h0, 2'b01);
    chk(ov, 6'h04);
    cfg(32'h2);
    pz(5'h08, 35'h0, 2'b00);
    chk(ov, 6'h04);
  endtask : t_swtrig
  // Lockup is sticky till reset, so this one runs last
  task automatic t_bus;
    cfg(32'h100);
    pz(5'h10, 35'h0, 2'b10);
    chk(ov, 6'h00);
    pz(5'h10, 35'h0, 2'b00);
    chk(ov, 6'h20);
    cfg(32'h0);
    pz(5'h10, 35'h0, 2'b10);
    chk(ov, 6'h10);
    pz(5'h00, 35'h0, 2'b00);
    chk(ov, 6'h10);
    wb(1'b0, `CDF_OFS_STAT, 32'h0);
    chk(rd, 32'h0000_001e);
    wb(1'b0, `CDF_OFS_EVT, 32'h0);
    chk(rd, 32'h0000_0002);
  endtask : t_bus
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Whole run needs under 300 cycles
  initial
  begin
    #20000;
    n_fail++;
    summarize();
  end
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, div_req_valid_i, div_req_i} = '0;
    {sev_i, event_clear_i, exc_entry_i, exc_return_i, stack_i, ret_to_thread_i} = '0;
    {nested_active_i, dbus_fault_i, hiprio_i, acc_valid_i, acc_i} = '0;
    {swtrig_wr_i, swtrig_priv_i} = 2'b00;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (12) tk();
    rst_i <= 1'b0;
    t_regs();
    t_div();
    t_sev();
    t_stack();
    t_acc();
    t_swtrig();
    t_bus();
    summarize();
  end
endmodule : cdf_core_tb
